// ==== pgmb_pkg.sv ====
// Package for the power-good mask bank: offsets, bit positions, reset tables
`default_nettype none
package pgmb_pkg;

  // Register offsets in the serial-bus register map
  localparam logic [7:0] PGMB_OFS_P4_FIRST  = 8'ha6;
  localparam logic [7:0] PGMB_OFS_P4_SECOND = 8'ha7;
  localparam logic [7:0] PGMB_OFS_P2_FIRST  = 8'ha8;
  localparam logic [7:0] PGMB_OFS_P2_SECOND = 8'ha9;
  localparam logic [7:0] PGMB_READ_NONE     = 8'h00;

  // First mask register bit positions
  localparam int PGMB_F_ADJ_SECOND = 7;
  localparam int PGMB_F_SWITCH_A1  = 6;
  localparam int PGMB_F_STEP_TOP   = 5;
  localparam int PGMB_F_STEP_LOW   = 0;

  // Second mask register bit positions
  localparam int PGMB_S_ENABLE_FIVE = 7;
  localparam int PGMB_S_ENABLE_FOUR = 6;
  localparam int PGMB_S_ENABLE_TWO  = 5;
  localparam int PGMB_S_ENABLE_ONE  = 4;
  localparam int PGMB_S_TERMINATION = 3;
  localparam int PGMB_S_SHARED      = 2;
  localparam int PGMB_S_SWITCH_B1   = 1;
  localparam int PGMB_S_ADJ_THIRD   = 0;

  localparam int PGMB_REG_W   = 8;
  localparam int PGMB_STEP_N  = 6;
  localparam int PGMB_SRC_N   = 16;
  localparam int PGMB_SYNC_N  = 3;

  // Factory variant whose shared slot carries load switch B2; the rest carry LDO A1
  localparam logic [1:0] PGMB_VARIANT_SWITCH = 2'h3;

  // Factory reset values, indexed by variant 0..3
  localparam logic [3:0][7:0] PGMB_RST_P4_FIRST  = {8'hff, 8'hf7, 8'hbf, 8'hf7};
  localparam logic [3:0][7:0] PGMB_RST_P4_SECOND = {8'hff, 8'h7f, 8'hff, 8'hbf};
  localparam logic [3:0][7:0] PGMB_RST_P2_FIRST  = {8'hc0, 8'hdf, 8'heb, 8'hdf};
  localparam logic [3:0][7:0] PGMB_RST_P2_SECOND = {8'hc7, 8'hff, 8'hfc, 8'h3f};

endpackage
`default_nettype wire

// ==== pgmb_sync_if.sv ====
// Interface carrying raw pin levels into the synchroniser and clean levels out
`timescale 1ns/100ps
`default_nettype none
interface pgmb_sync_if #(
  parameter int WIDTH = 16
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface
`default_nettype wire

// ==== pgmb_sync.sv ====
// Three-flop synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/100ps
`default_nettype none
module pgmb_sync
  import pgmb_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic      clk_in,
  input  wire logic      srst_in,
  pgmb_sync_if.filt      sif
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] clean;
  } pgmb_sync_state_t;

  pgmb_sync_state_t st;
  pgmb_sync_state_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = sif.raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // A change counts once stages two and three agree
    for (int i = 0; i < WIDTH; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.clean[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sif.clean = st.clean;
endmodule
`default_nettype wire

// ==== pgmb_top.sv ====
// Power-good mask bank: four mask registers and two power-good trees
// Notes on behaviour
// - Pin four first mask: LDO2, switch A1, steps
// - Pin four second mask high nibble: enable inputs
// - Pin four second mask low nibble: other rails
// - Shared bit-2 slot follows factory variant
// - Pin two first mask at A8h, same layout
// - Pin four second at A7h, RW, variant reset
`timescale 1ns/100ps
`default_nettype none
module pgmb_top
  import pgmb_pkg::*;
#(
  parameter logic [1:0] VARIANT = 2'h0
) (
  input  wire logic                  clk_in,
  input  wire logic                  srst_in,
  input  wire logic [PGMB_REG_W-1:0] reg_addr_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  input  wire logic [PGMB_REG_W-1:0] reg_wdata_in,
  output logic      [PGMB_REG_W-1:0] reg_rdata_out,
  output logic                       reg_ack_out,
  input  wire logic [PGMB_STEP_N-1:0] stepdown_rail_good_in,
  input  wire logic                  adjustable_linear_first_good_in,
  input  wire logic                  adjustable_linear_second_good_in,
  input  wire logic                  adjustable_linear_third_good_in,
  input  wire logic                  load_switch_a_one_good_in,
  input  wire logic                  load_switch_b_one_good_in,
  input  wire logic                  load_switch_b_two_good_in,
  input  wire logic                  termination_linear_good_in,
  input  wire logic                  enable_input_one_in,
  input  wire logic                  enable_input_two_in,
  input  wire logic                  enable_input_four_in,
  input  wire logic                  enable_input_five_in,
  output logic                       general_output_four_out,
  output logic                       general_output_two_out
);

  // Raw source positions on the synchroniser bus
  localparam int SRC_STEP_LOW  = 0;
  localparam int SRC_ADJ_FIRST = 6;
  localparam int SRC_ADJ_SEC   = 7;
  localparam int SRC_ADJ_THIRD = 8;
  localparam int SRC_SW_A1     = 9;
  localparam int SRC_SW_B1     = 10;
  localparam int SRC_SW_B2     = 11;
  localparam int SRC_TERM      = 12;
  localparam int SRC_EN_ONE    = 13;
  localparam int SRC_EN_TWO    = 14;
  localparam int SRC_EN_FOUR   = 15;
  localparam int SRC_EN_FIVE   = 16;
  localparam int SRC_W         = 17;

  typedef struct packed {
    logic [PGMB_REG_W-1:0] p4_first;
    logic [PGMB_REG_W-1:0] p4_second;
    logic [PGMB_REG_W-1:0] p2_first;
    logic [PGMB_REG_W-1:0] p2_second;
    logic                  out_four;
    logic                  out_two;
    logic [PGMB_REG_W-1:0] rdata;
    logic                  ack;
  } pgmb_state_t;

  pgmb_state_t st;
  pgmb_state_t next_st;

  logic [PGMB_REG_W-1:0] src_first;
  logic [PGMB_REG_W-1:0] src_second;
  logic                  shared_good;

  pgmb_sync_if #(.WIDTH(SRC_W)) sync_bus ();

  // All good and enable levels arrive from outside this clock domain
  assign sync_bus.raw[SRC_STEP_LOW +: PGMB_STEP_N] = stepdown_rail_good_in;
  assign sync_bus.raw[SRC_ADJ_FIRST]               = adjustable_linear_first_good_in;
  assign sync_bus.raw[SRC_ADJ_SEC]                 = adjustable_linear_second_good_in;
  assign sync_bus.raw[SRC_ADJ_THIRD]               = adjustable_linear_third_good_in;
  assign sync_bus.raw[SRC_SW_A1]                   = load_switch_a_one_good_in;
  assign sync_bus.raw[SRC_SW_B1]                   = load_switch_b_one_good_in;
  assign sync_bus.raw[SRC_SW_B2]                   = load_switch_b_two_good_in;
  assign sync_bus.raw[SRC_TERM]                    = termination_linear_good_in;
  assign sync_bus.raw[SRC_EN_ONE]                  = enable_input_one_in;
  assign sync_bus.raw[SRC_EN_TWO]                  = enable_input_two_in;
  assign sync_bus.raw[SRC_EN_FOUR]                 = enable_input_four_in;
  assign sync_bus.raw[SRC_EN_FIVE]                 = enable_input_five_in;

  pgmb_sync #(
    .WIDTH (SRC_W)
  ) u_sync (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .sif     (sync_bus.filt)
  );

  // Shared slot carries switch B2 on one variant, LDO A1 on the others
  always_comb begin
    if (VARIANT == PGMB_VARIANT_SWITCH) begin
      shared_good = sync_bus.clean[SRC_SW_B2];
    end else begin
      shared_good = sync_bus.clean[SRC_ADJ_FIRST];
    end
  end

  // Source vectors laid out bit for bit like the mask registers
  always_comb begin
    src_first                                   = '0;
    src_first[PGMB_F_ADJ_SECOND]                = sync_bus.clean[SRC_ADJ_SEC];
    src_first[PGMB_F_SWITCH_A1]                 = sync_bus.clean[SRC_SW_A1];
    src_first[PGMB_F_STEP_TOP:PGMB_F_STEP_LOW]  = sync_bus.clean[SRC_STEP_LOW +: PGMB_STEP_N];
  end

  always_comb begin
    src_second                     = '0;
    src_second[PGMB_S_ENABLE_FIVE] = sync_bus.clean[SRC_EN_FIVE];
    src_second[PGMB_S_ENABLE_FOUR] = sync_bus.clean[SRC_EN_FOUR];
    src_second[PGMB_S_ENABLE_TWO]  = sync_bus.clean[SRC_EN_TWO];
    src_second[PGMB_S_ENABLE_ONE]  = sync_bus.clean[SRC_EN_ONE];
    src_second[PGMB_S_TERMINATION] = sync_bus.clean[SRC_TERM];
    src_second[PGMB_S_SHARED]      = shared_good;
    src_second[PGMB_S_SWITCH_B1]   = sync_bus.clean[SRC_SW_B1];
    src_second[PGMB_S_ADJ_THIRD]   = sync_bus.clean[SRC_ADJ_THIRD];
  end

  always_comb begin
    next_st     = st;
    next_st.ack = 1'b0;

    // Register writes; unmapped offsets are ignored
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        PGMB_OFS_P4_FIRST: begin
          next_st.p4_first = reg_wdata_in;
        end
        PGMB_OFS_P4_SECOND: begin
          next_st.p4_second = reg_wdata_in;
        end
        PGMB_OFS_P2_FIRST: begin
          next_st.p2_first = reg_wdata_in;
        end
        PGMB_OFS_P2_SECOND: begin
          next_st.p2_second = reg_wdata_in;
        end
        default: begin
          next_st.p4_first = st.p4_first;
        end
      endcase
    end

    // Register reads; unmapped offsets read zero
    if (reg_rd_in) begin
      next_st.ack = 1'b1;
      unique case (reg_addr_in)
        PGMB_OFS_P4_FIRST: begin
          next_st.rdata = st.p4_first;
        end
        PGMB_OFS_P4_SECOND: begin
          next_st.rdata = st.p4_second;
        end
        PGMB_OFS_P2_FIRST: begin
          next_st.rdata = st.p2_first;
        end
        PGMB_OFS_P2_SECOND: begin
          next_st.rdata = st.p2_second;
        end
        default: begin
          next_st.rdata = PGMB_READ_NONE;
        end
      endcase
    end

    // A set mask bit forces its source to count as good
    next_st.out_four = &(src_first | st.p4_first) & &(src_second | st.p4_second);
    next_st.out_two  = &(src_first | st.p2_first) & &(src_second | st.p2_second);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st           <= '0;
      st.p4_first  <= PGMB_RST_P4_FIRST[VARIANT];
      st.p4_second <= PGMB_RST_P4_SECOND[VARIANT];
      st.p2_first  <= PGMB_RST_P2_FIRST[VARIANT];
      st.p2_second <= PGMB_RST_P2_SECOND[VARIANT];
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_out           = st.rdata;
  assign reg_ack_out             = st.ack;
  assign general_output_four_out = st.out_four;
  assign general_output_two_out  = st.out_two;

endmodule
`default_nettype wire

// ==== pgmb_assertions.sv ====
// Port checker for the power-good mask bank
`timescale 1ns/100ps
`default_nettype none
module pgmb_checker
  import pgmb_pkg::*;
(
  input wire logic                   clk_in,
  input wire logic                   srst_in,
  input wire logic [PGMB_REG_W-1:0]  reg_addr_in,
  input wire logic                   reg_wr_in,
  input wire logic                   reg_rd_in,
  input wire logic [PGMB_REG_W-1:0]  reg_rdata_out,
  input wire logic                   reg_ack_out,
  input wire logic [PGMB_STEP_N-1:0] stepdown_rail_good_in,
  input wire logic                   adjustable_linear_first_good_in,
  input wire logic                   adjustable_linear_second_good_in,
  input wire logic                   adjustable_linear_third_good_in,
  input wire logic                   load_switch_a_one_good_in,
  input wire logic                   load_switch_b_one_good_in,
  input wire logic                   load_switch_b_two_good_in,
  input wire logic                   termination_linear_good_in,
  input wire logic                   enable_input_one_in,
  input wire logic                   enable_input_two_in,
  input wire logic                   enable_input_four_in,
  input wire logic                   enable_input_five_in,
  input wire logic                   general_output_four_out,
  input wire logic                   general_output_two_out
);
  logic [2:0]  settle;
  wire logic [16:0] src = {stepdown_rail_good_in, adjustable_linear_first_good_in,
    adjustable_linear_second_good_in, adjustable_linear_third_good_in, load_switch_a_one_good_in,
    load_switch_b_one_good_in, load_switch_b_two_good_in, termination_linear_good_in,
    enable_input_one_in, enable_input_two_in, enable_input_four_in, enable_input_five_in};

  // Counts edges since reset so the refilling synchroniser is not blamed
  always_ff @(posedge clk_in) begin
    if (srst_in) settle <= 3'h0;
    else if (settle != 3'h7) settle <= settle + 3'h1;
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);

  read_ack_a: assert property (reg_rd_in |=> reg_ack_out)
    else $error("read not answered in the next cycle");
  ack_cause_a: assert property (reg_ack_out |-> $past(reg_rd_in))
    else $error("answer without a read");
  unmapped_zero_a: assert property (
    reg_rd_in && (reg_addr_in < PGMB_OFS_P4_FIRST || reg_addr_in > PGMB_OFS_P2_SECOND)
    |=> reg_rdata_out == PGMB_READ_NONE) else $error("unmapped read not zero");
  rdata_hold_a: assert property (!reg_ack_out && !$past(srst_in) |-> $stable(reg_rdata_out))
    else $error("read data moved without a read");
  reset_low_a: assert property (disable iff (1'b0) srst_in |=> !general_output_four_out
    && !general_output_two_out && !reg_ack_out) else $error("outputs not low in reset");
  four_cause_a: assert property ($changed(general_output_four_out) && settle == 3'h7 |->
    $past(reg_wr_in, 2) || $past(reg_wr_in, 3) || $past(src, 4) != $past(src, 8))
    else $error("pin four output moved without a cause");
  two_cause_a: assert property ($changed(general_output_two_out) && settle == 3'h7 |->
    $past(reg_wr_in, 2) || $past(reg_wr_in, 3) || $past(src, 4) != $past(src, 8))
    else $error("pin two output moved without a cause");

  cover property (reg_rd_in && reg_addr_in == PGMB_OFS_P4_SECOND);
  cover property ($fell(general_output_four_out));
  cover property ($rose(general_output_two_out));
endmodule

bind pgmb_top pgmb_checker i_pgmb_checker (
  .clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out),
  .stepdown_rail_good_in(stepdown_rail_good_in),
  .adjustable_linear_first_good_in(adjustable_linear_first_good_in),
  .adjustable_linear_second_good_in(adjustable_linear_second_good_in),
  .adjustable_linear_third_good_in(adjustable_linear_third_good_in),
  .load_switch_a_one_good_in(load_switch_a_one_good_in), .load_switch_b_one_good_in(load_switch_b_one_good_in),
  .load_switch_b_two_good_in(load_switch_b_two_good_in), .termination_linear_good_in(termination_linear_good_in),
  .enable_input_one_in(enable_input_one_in), .enable_input_two_in(enable_input_two_in),
  .enable_input_four_in(enable_input_four_in), .enable_input_five_in(enable_input_five_in),
  .general_output_four_out(general_output_four_out), .general_output_two_out(general_output_two_out)
);
`default_nettype wire

// ==== testbench.sv ====
// Self-checking testbench for the power-good mask bank
`timescale 1ns/100ps
`default_nettype none
module testbench
  import pgmb_pkg::*;
();
  logic        clk_in, srst_in, wr, rd, ack, out4, out2, load_switch_b_two;
  logic [7:0]  addr, wdata, rdata;
  logic [15:0] src;
  int          n_mismatch, num_checks;

  pgmb_top #(.VARIANT(2'h0)) i_pgmb_top (
    .clk_in(clk_in), .srst_in(srst_in), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_ack_out(ack), .stepdown_rail_good_in(src[5:0]),
    .adjustable_linear_first_good_in(src[10]), .adjustable_linear_second_good_in(src[7]),
    .adjustable_linear_third_good_in(src[8]), .load_switch_a_one_good_in(src[6]),
    .load_switch_b_one_good_in(src[9]), .load_switch_b_two_good_in(load_switch_b_two),
    .termination_linear_good_in(src[11]), .enable_input_one_in(src[12]), .enable_input_two_in(src[13]),
    .enable_input_four_in(src[14]), .enable_input_five_in(src[15]),
    .general_output_four_out(out4), .general_output_two_out(out2)
  );

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    cmp({7'h0, ack}, 8'h01);
    cmp(rdata, exp);
    tick(1);
  endtask

  // Reset values, write and read back, unmapped places, reset in mid-run
  task automatic test_regs;
    rd_reg(PGMB_OFS_P4_FIRST, PGMB_RST_P4_FIRST[0]);
    rd_reg(PGMB_OFS_P4_SECOND, PGMB_RST_P4_SECOND[0]);
    rd_reg(PGMB_OFS_P2_FIRST, PGMB_RST_P2_FIRST[0]);
    rd_reg(PGMB_OFS_P2_SECOND, PGMB_RST_P2_SECOND[0]);
    for (int r = 0; r < 4; r++) wr_reg(PGMB_OFS_P4_FIRST + 8'(r), 8'h5a ^ 8'(r));
    wr_reg(8'ha5, 8'h33);
    wr_reg(8'haa, 8'h33);
    for (int r = 0; r < 4; r++) rd_reg(PGMB_OFS_P4_FIRST + 8'(r), 8'h5a ^ 8'(r));
    rd_reg(8'ha5, PGMB_READ_NONE);
    rd_reg(8'haa, PGMB_READ_NONE);
    srst_in = 1'b1;
    tick(4);
    srst_in = 1'b0;
    rd_reg(PGMB_OFS_P4_SECOND, PGMB_RST_P4_SECOND[0]);
  endtask

  // Each of 16 sources alone drops both pins, then each pin's mask bit removes it; B2 alone drops neither
  task automatic test_tree;
    for (int i = 0; i < 16; i++) begin
      for (int r = 0; r < 4; r++) wr_reg(PGMB_OFS_P4_FIRST + 8'(r), 8'h00);
      tick(8);
      cmp({6'h0, out4, out2}, 8'h03);
      src[i] = 1'b0;
      tick(8);
      cmp({6'h0, out4, out2}, 8'h00);
      wr_reg((i < 8) ? PGMB_OFS_P4_FIRST : PGMB_OFS_P4_SECOND, 8'h01 << (i % 8));
      tick(3);
      cmp({6'h0, out4, out2}, 8'h02);
      wr_reg((i < 8) ? PGMB_OFS_P2_FIRST : PGMB_OFS_P2_SECOND, 8'h01 << (i % 8));
      tick(3);
      cmp({6'h0, out4, out2}, 8'h03);
      src[i] = 1'b1;
    end
    for (int r = 0; r < 4; r++) wr_reg(PGMB_OFS_P4_FIRST + 8'(r), 8'h00);
    load_switch_b_two = 1'b0;
    tick(8);
    cmp({6'h0, out4, out2}, 8'h03);
    load_switch_b_two = 1'b1;
  endtask

  task automatic end_of_test;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #(25 * 4000);
    n_mismatch++;
    end_of_test;
  end

  initial begin
    n_mismatch = 0;
    num_checks = 0;
    srst_in = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    src = 16'hffff;
    load_switch_b_two = 1'b1;
    tick(4);
    srst_in = 1'b0;
    test_regs;
    test_tree;
    end_of_test;
  end
endmodule
`default_nettype wire
